// >>> flash_protect_security_test.sv
// self-checking bench for the flash guard
`timescale 1ns/1ps
`include "fps_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module flash_protect_security_test;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int          OPC  = 20;                       // shortened operation
    localparam logic        rd_c = 1'b0;                     // row reads
    localparam logic        wr_c = 1'b1;                     // row writes
    localparam logic [15:0] ar = 16'h1000, st = `FPS_OFF_STAT, dv = `FPS_OFF_DIV;
    localparam logic [15:0] cm = `FPS_OFF_CMD, cf = `FPS_OFF_CFG, pr = `FPS_OFF_PROT;
    localparam logic [15:0] op = `FPS_OFF_OPT, mi = `FPS_OFF_MISC, rs = `FPS_OFF_KEYCMP;
    localparam logic [7:0]  z = 8'h00, e = 8'h10, f = 8'hFF, c = 8'h90;
    localparam logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    typedef struct packed {
        logic        we;   // direction
        logic [15:0] adr;  // byte address
        logic [7:0]  dat;  // write data
        logic [7:0]  msk;  // bits compared
        logic [7:0]  exp;  // expected read bits
    } fps_row_type;
    logic        mclk, rst_n, halt_req, debug_mode_pin, dbg_enable_req, flash_blank;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dbg_access, unsecure_code;
    logic        vec_fetch, mem_wr_o, op_start_o, secure_o, bgnd_mode_o, dbg_en_o;
    logic [3:0]  wb_sel_i;
    logic [7:0]  nv_prot, nv_opt, op_cmd_o, op_dat_o, rd;
    logic [15:0] wb_adr_i, fetch_adr, fetch_adr_o, op_adr_o;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [63:0] nv_key;
    int          miscompares, num_checks, starts, writes, n;
    // protocol table: each error case but the repeated command ends by clearing the error flag; that one first runs a sequence with the flag set
    fps_row_type rows [43] = '{
        '{rd_c, rs, z, f, z}, '{rd_c, st, z, e, z}, '{rd_c, dv, z, f, z},
        '{rd_c, op, z, 8'hC3, 8'h82}, '{rd_c, pr, z, f, 8'hFC}, '{rd_c, mi, z, 8'h02, z},
        '{wr_c, ar, 8'h5A, z, z}, '{rd_c, st, z, e, e}, '{wr_c, st, c, z, z},
        '{rd_c, st, z, e, z}, '{wr_c, dv, 8'h13, z, z}, '{rd_c, dv, z, f, 8'h93},
        '{wr_c, pr, z, z, z}, '{rd_c, pr, z, f, 8'hFC},
        '{wr_c, ar, 8'h11, z, z}, '{wr_c, ar, 8'h22, z, z}, '{rd_c, st, z, e, e},
        '{wr_c, st, c, z, z}, '{wr_c, ar, 8'h11, z, z}, '{wr_c, cf, z, z, z},
        '{rd_c, st, z, e, e}, '{wr_c, st, c, z, z}, '{wr_c, ar, 8'h11, z, z},
        '{wr_c, cm, 8'h21, z, z}, '{rd_c, st, z, e, e}, '{wr_c, st, c, z, z},
        '{wr_c, ar, 8'h11, z, z}, '{wr_c, cm, 8'h20, z, z}, '{rd_c, cf, z, z, z},
        '{rd_c, st, z, e, e}, '{wr_c, st, c, z, z}, '{wr_c, ar, 8'h11, z, z},
        '{wr_c, st, e, z, z}, '{rd_c, st, z, e, e}, '{wr_c, st, c, z, z},
        '{wr_c, ar, 8'h11, z, z}, '{wr_c, cm, 8'h20, z, z}, '{wr_c, cm, 8'h20, z, z},
        '{rd_c, st, z, e, e}, '{wr_c, ar, 8'h11, z, z}, '{wr_c, cm, 8'h20, z, z},
        '{wr_c, st, 8'h80, z, z}, '{wr_c, st, c, z, z}};
    ////////////////////////////////////////////////////////////////////////////////
    fps_guard #(.OP_CYCLES(OPC)) fps_guard_inst (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dbg_access,
        .unsecure_code, .halt_req, .debug_mode_pin, .dbg_enable_req, .nv_prot, .nv_opt,
        .nv_key, .flash_blank, .vec_fetch, .fetch_adr, .fetch_adr_o, .mem_wr_o,
        .op_start_o, .op_cmd_o, .op_adr_o, .op_dat_o, .secure_o, .bgnd_mode_o, .dbg_en_o);
    fps_host fps_host_inst (.mclk, .wb_dat_o, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .dbg_access, .unsecure_code);
    ////////////////////////////////////////////////////////////////////////////////
    // clock and launch / array write counters
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (op_start_o === 1'b1) starts++;
        if (mem_wr_o === 1'b1) writes++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic w(input logic [15:0] a, input logic [7:0] d, input logic [1:0] s = 2'b00);
        fps_host_inst.xfer(1'b1, a, d, s, rd);
    endtask : w
    task automatic rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
        fps_host_inst.xfer(1'b0, a, z, 2'b00, rd);
        `CHK(rd & m, x)
    endtask : rchk
    // full command sequence, then wait out the operation
    task automatic seq(input logic [15:0] a, input logic [7:0] k, input logic [1:0] s = 2'b00);
        w(a, 8'h5A, s);
        w(cm, k, s);
        w(st, 8'h80, s);
        repeat (OPC + 4) @(posedge mclk);
    endtask : seq
    task automatic rst;
        rst_n <= 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : rst
    task automatic keys;
        w(cf, 8'h20);
        for (int i = 0; i < 8; i++) w(16'hFFB8 + 16'(i), nv_key[8*i +: 8]);
        w(cf, z);
        repeat (2) @(posedge mclk);
    endtask : keys
    task automatic results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // watchdog well past the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        halt_req = 1'b0;
        debug_mode_pin = 1'b1;
        dbg_enable_req = 1'b0;
        flash_blank = 1'b0;
        vec_fetch = 1'b0;
        fetch_adr = 16'h0000;
        nv_prot = 8'hFC;
        nv_opt = 8'h82;
        nv_key = 64'h0123456789ABCDEF;
        rst();
        foreach (rows[i]) begin
            fps_host_inst.xfer(rows[i].we, rows[i].adr, rows[i].dat, 2'b00, rd);
            if (!rows[i].we) `CHK(rd & rows[i].msk, rows[i].exp)
        end
        `CHK(starts, 0)
        n = writes;
        for (int i = 0; i < 5; i++) begin
            seq(ar + 16'(i), codes[i]);
            if (codes[i] == `FPS_CMD_MASS) begin
                rchk(st, e, e);
                w(st, c);
            end else begin
                `CHK(op_cmd_o, codes[i])
                `CHK(op_adr_o, ar + 16'(i))
                `CHK(op_dat_o, 8'h5A)
            end
        end
        `CHK(writes, n + 5)
        `CHK(starts, 4)
        seq(16'hFE10, 8'h20);
        w(st, c);
        `CHK(starts, 4)
        w(ar, 8'h5A);
        w(cm, 8'h40);
        w(st, 8'h80);
        halt_req <= 1'b1;
        @(posedge mclk);
        halt_req <= 1'b0;
        rchk(st, e, e);
        w(st, c);
        w(ar, 8'h5A);
        w(cm, 8'h20);
        w(st, 8'h80);
        w(ar, 8'h5A);
        rchk(st, e, e);
        w(st, c);
        vec_fetch <= 1'b1;
        fetch_adr <= 16'hFFE0;
        repeat (2) @(posedge mclk);
        `CHK(fetch_adr_o, 16'hFDE0)
        fetch_adr <= 16'hFFFE;
        repeat (2) @(posedge mclk);
        `CHK(fetch_adr_o, 16'hFFFE)
        nv_opt <= 8'h83;
        debug_mode_pin <= 1'b0;
        dbg_enable_req <= 1'b1;
        rst();
        `CHK(secure_o, 1'b1)
        `CHK(bgnd_mode_o, 1'b1)
        `CHK(dbg_en_o, 1'b0)
        w(dv, 8'h13);
        n = writes;
        w(ar, 8'h5A, 2'b10);
        @(posedge mclk);
        `CHK(writes, n)
        fps_host_inst.xfer(1'b0, ar, z, 2'b10, rd);
        `CHK(rd, z)
        w(ar, 8'h5A, 2'b01);
        w(cm, 8'h20, 2'b01);
        rchk(st, e, e);
        w(st, c);
        keys();
        `CHK(secure_o, 1'b0)
        nv_opt <= 8'h03;
        rst();
        w(dv, 8'h13);
        keys();
        `CHK(secure_o, 1'b1)
        w(st, c);
        flash_blank <= 1'b1;
        w(pr, f, 2'b01);
        seq(ar, 8'h05, 2'b01);
        `CHK(secure_o, 1'b0)
        results();
    end
endmodule : flash_protect_security_test

// >>> fps_guard.sv
// flash protection, access error and security guard with a wishbone register slave
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "fps_regs.svh"
module fps_guard #(
    parameter int OP_CYCLES = `FPS_OP_CYCLES  // length of a program or erase
) (
    input  wire logic        mclk,          // bus clock
    input  wire logic        rst_n,         // synchronous reset, active low
    input  wire logic        wb_cyc_i,      // wishbone cycle
    input  wire logic        wb_stb_i,      // wishbone strobe
    input  wire logic        wb_we_i,       // write enable
    input  wire logic [15:0] wb_adr_i,      // byte address
    input  wire logic [3:0]  wb_sel_i,      // byte lanes
    input  wire logic [31:0] wb_dat_i,      // write data
    output logic      [31:0] wb_dat_o,      // read data
    output logic             wb_ack_o,      // acknowledge
    input  wire logic        dbg_access,    // access comes from the debug controller
    input  wire logic        unsecure_code, // access from code in unsecured space
    input  wire logic        halt_req,      // processor enters low-power halt
    input  wire logic        debug_mode_pin,// mode strap pin, low selects background
    input  wire logic        dbg_enable_req,// request to enable the debug module
    input  wire logic [7:0]  nv_prot,       // nonvolatile protection byte
    input  wire logic [7:0]  nv_opt,        // nonvolatile option byte
    input  wire logic [63:0] nv_key,        // stored backdoor key
    input  wire logic        flash_blank,   // flash array reads fully erased
    input  wire logic        vec_fetch,     // current fetch is a vector fetch
    input  wire logic [15:0] fetch_adr,     // fetch address
    output logic      [15:0] fetch_adr_o,   // redirected fetch address
    output logic             mem_wr_o,      // array write reaching flash/ram
    output logic             op_start_o,    // program/erase operation launched
    output logic      [7:0]  op_cmd_o,      // launched command
    output logic      [15:0] op_adr_o,      // launched address
    output logic      [7:0]  op_dat_o,      // launched data
    output logic             secure_o,      // device secured
    output logic             bgnd_mode_o,   // active background mode strap
    output logic             dbg_en_o       // debug module enabled
);
    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (OP_CYCLES < 1) begin : g_chk
        $error("OP_CYCLES must be at least one");
    end

    // decode one register word address
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // state
    fps_pkg::fps_state_type state_ff, nxt_state;  // command sequence
    logic        accerr_ff;       // access error flag
    logic        divld_ff;        // divider written since reset
    logic [6:0]  div_ff;          // divider value
    logic [7:0]  prot_ff;         // working protection register
    logic [7:0]  opt_ff;          // working options register
    logic        key_access_bit_ff;       // key access bit
    logic [2:0]  keyidx_ff;       // next key byte slot
    logic [63:0] keybuf_ff;       // entered key bytes
    logic [3:0]  keycnt_ff;       // key bytes entered
    logic        unlock_ff;       // security forced open until reset
    logic        loaded_ff;       // nonvolatile copies taken
    logic [15:0] adr_ff;          // latched array address
    logic [7:0]  dat_ff;          // latched array data
    logic [7:0]  cmd_ff;          // latched command
    logic [$clog2(OP_CYCLES+1)-1:0] opcnt_ff; // operation timer
    logic        launched_ff;     // strap already taken since reset

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr       = req & wb_we_i & wb_sel_i[0];
    wire        rd       = req & ~wb_we_i;
    wire [7:0]  wd       = wb_dat_i[7:0];
    wire        is_div   = hit(wb_adr_i, `FPS_OFF_DIV);
    wire        is_opt   = hit(wb_adr_i, `FPS_OFF_OPT);
    wire        is_cfg   = hit(wb_adr_i, `FPS_OFF_CFG);
    wire        is_prot  = hit(wb_adr_i, `FPS_OFF_PROT);
    wire        is_stat  = hit(wb_adr_i, `FPS_OFF_STAT);
    wire        is_cmd   = hit(wb_adr_i, `FPS_OFF_CMD);
    wire        is_misc  = hit(wb_adr_i, `FPS_OFF_MISC);
    wire        is_ctl   = is_div | is_opt | is_cfg | is_prot | is_stat | is_cmd;
    wire        is_array = ~is_ctl & ~is_misc & ~hit(wb_adr_i, `FPS_OFF_KEYCMP)
                           & (wb_adr_i >= 16'h0020);
    // security field decode: only binary 10 leaves the part open
    wire        secured  = (opt_ff[1:0] != `FPS_SEC_OPEN) & ~unlock_ff;
    // untrusted master on a secured part
    wire        blocked  = secured & (dbg_access | unsecure_code);
    // key capture window
    wire        key_wr   = wr & is_array & key_access_bit_ff & (wb_adr_i[15:3] == 13'h1FF7);

    ////////////////////////////////////////////////////////////////////////////
    // protection boundary
    wire [15:0] last_unprot = {prot_ff[7:1], 9'h1FF};
    wire        prot_on     = ~prot_ff[`FPS_BIT_PDIS];
    wire        in_prot     = prot_on & (adr_ff > last_unprot);
    wire        part_prot   = prot_on & (prot_ff[7:1] != 7'h00);
    wire        redirect    = ~opt_ff[`FPS_BIT_NORED] & part_prot & vec_fetch
                              & (fetch_adr >= `FPS_VEC_LO) & (fetch_adr <= `FPS_VEC_HI);
    wire [15:0] redir_adr   = {prot_ff[7:1], fetch_adr[8:0]};

    ////////////////////////////////////////////////////////////////////////////
    // error sources of the command protocol
    wire valid_cmd = (wd == `FPS_CMD_BLANK) | (wd == `FPS_CMD_BYTE) | (wd == `FPS_CMD_BURST)
                     | (wd == `FPS_CMD_PAGE) | (wd == `FPS_CMD_MASS);
    wire dbg_bad   = dbg_access & secured & (wd != `FPS_CMD_BLANK) & (wd != `FPS_CMD_MASS);
    // debug may still open a command while secured; the array itself stays shut
    wire arr_wr    = wr & is_array & ~key_wr & ~(secured & unsecure_code);
    wire busy      = (state_ff == fps_pkg::FPS_BUSY);
    wire launch_wr = wr & is_stat & wd[`FPS_BIT_CBEF];
    wire e_div     = arr_wr & ~divld_ff;
    wire e_cbef    = arr_wr & busy;
    wire e_second  = (arr_wr & (state_ff != fps_pkg::FPS_IDLE) & ~busy)
                     | (wr & is_cmd & (state_ff == fps_pkg::FPS_CMDQ));
    wire e_ctlwr   = wr & (state_ff == fps_pkg::FPS_ADDR) & is_ctl & ~is_cmd
                     & ~(is_stat & ~wd[`FPS_BIT_CBEF]);
    wire e_code    = wr & is_cmd & (state_ff == fps_pkg::FPS_ADDR)
                     & (~valid_cmd | dbg_bad);
    wire e_after   = (state_ff == fps_pkg::FPS_CMDQ) & (rd | wr) & is_ctl
                     & ~launch_wr & ~(wr & is_cmd);
    wire e_halt    = halt_req & busy;
    wire e_cancel  = wr & is_stat & ~wd[`FPS_BIT_CBEF]
                     & (state_ff == fps_pkg::FPS_ADDR || state_ff == fps_pkg::FPS_CMDQ);
    wire e_prot    = launch_wr & (state_ff == fps_pkg::FPS_CMDQ)
                     & (cmd_ff != `FPS_CMD_BLANK) & (in_prot | (cmd_ff == `FPS_CMD_MASS & prot_on));
    wire any_err   = e_div | e_cbef | e_second | e_ctlwr | e_code | e_after
                     | e_halt | e_cancel | e_prot;
    wire clr_err   = wr & is_stat & wd[`FPS_BIT_ACCERR];
    wire go        = launch_wr & (state_ff == fps_pkg::FPS_CMDQ) & ~accerr_ff & ~any_err;
    wire op_done   = busy & (opcnt_ff == '0);

    ////////////////////////////////////////////////////////////////////////////
    // sequence next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fps_pkg::FPS_IDLE: begin
                // array write opens a sequence unless the flag blocks it
                if (arr_wr & ~accerr_ff & ~any_err) nxt_state = fps_pkg::FPS_ADDR;
            end
            fps_pkg::FPS_ADDR: begin
                if (wr & is_cmd & ~any_err) nxt_state = fps_pkg::FPS_CMDQ;
            end
            fps_pkg::FPS_CMDQ: begin
                if (go) nxt_state = fps_pkg::FPS_BUSY;
            end
            fps_pkg::FPS_BUSY: begin
                if (op_done) nxt_state = fps_pkg::FPS_IDLE;
            end
            default: nxt_state = fps_pkg::FPS_IDLE;
        endcase
        // error drops the partial sequence or aborts the running one
        if (any_err) nxt_state = fps_pkg::FPS_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence and error flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff  <= fps_pkg::FPS_IDLE;
            accerr_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            // set wins over the clear
            accerr_ff <= any_err | (accerr_ff & ~clr_err);
        end
    end

    // latched address, data and command
    always_ff @(posedge mclk) begin
        if (!rst_n || any_err) begin
            adr_ff <= 16'h0000;
            dat_ff <= 8'h00;
            cmd_ff <= 8'h00;
        end else begin
            if (arr_wr && state_ff == fps_pkg::FPS_IDLE) begin
                adr_ff <= wb_adr_i;
                dat_ff <= wd;
            end
            if (wr && is_cmd && state_ff == fps_pkg::FPS_ADDR) cmd_ff <= wd;
        end
    end

    // operation timer
    always_ff @(posedge mclk) begin
        if (!rst_n) opcnt_ff <= '0;
        else if (go) opcnt_ff <= ($clog2(OP_CYCLES+1))'(OP_CYCLES - 1);
        else if (busy && opcnt_ff != '0) opcnt_ff <= opcnt_ff - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider, config, protection and options
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            divld_ff  <= 1'b0;
            div_ff    <= 7'h00;
            key_access_bit_ff <= 1'b0;
            loaded_ff <= 1'b0;
            prot_ff   <= 8'hFF;
            opt_ff    <= 8'hFF;
        end else begin
            // nonvolatile copies taken on the first clock after reset
            if (!loaded_ff) begin
                prot_ff   <= nv_prot;
                opt_ff    <= nv_opt;
                loaded_ff <= 1'b1;
            end else if (wr && is_prot && dbg_access && !any_err) begin
                prot_ff   <= wd;
            end
            // divider loads once, not while the flag stands
            if (wr && is_div && !divld_ff && !accerr_ff && !any_err) begin
                div_ff    <= wd[6:0];
                divld_ff  <= 1'b1;
            end
            if (wr && is_cfg && !any_err && !blocked)
                key_access_bit_ff <= wd[`FPS_BIT_KEY_ACCESS_BIT] & opt_ff[`FPS_BIT_BACKDOOR_KEY_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // backdoor key capture and compare
    wire key_close = wr & is_cfg & key_access_bit_ff & ~wd[`FPS_BIT_KEY_ACCESS_BIT];
    wire key_match = (keycnt_ff == 4'h8) & (keybuf_ff == nv_key);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            keyidx_ff <= 3'h0;
            keycnt_ff <= 4'h0;
            keybuf_ff <= 64'h0;
            unlock_ff <= 1'b0;
        end else begin
            // ascending order only; an out-of-order byte spoils the count
            if (key_wr && !unsecure_code && !dbg_access) begin
                keybuf_ff[keyidx_ff*8 +: 8] <= wd;
                keyidx_ff <= keyidx_ff + 3'h1;
                keycnt_ff <= (wb_adr_i[2:0] == keyidx_ff) ? keycnt_ff + 4'h1 : 4'hF;
            end
            if (key_close) begin
                keyidx_ff <= 3'h0;
                keycnt_ff <= 4'h0;
            end
            // key match or blank check of an erased flash opens the part
            if ((key_close && key_match && opt_ff[`FPS_BIT_BACKDOOR_KEY_ENABLE])
                || (op_done && cmd_ff == `FPS_CMD_BLANK && flash_blank))
                unlock_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] stat_rd = {~(state_ff == fps_pkg::FPS_ADDR || state_ff == fps_pkg::FPS_CMDQ
                           || busy), ~busy, 1'b0, accerr_ff, 4'h0};
    wire [7:0] rd_byte = is_div  ? {divld_ff, div_ff}
                       : is_opt  ? {opt_ff[7:2], unlock_ff ? `FPS_SEC_OPEN : opt_ff[1:0]}
                       : is_cfg  ? {2'b00, key_access_bit_ff, 5'h00}
                       : is_prot ? prot_ff
                       : is_stat ? stat_rd
                       : is_cmd  ? cmd_ff
                       : is_misc ? {6'h00, secured, divld_ff}
                       : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // bus answer and outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0;
            mem_wr_o    <= 1'b0;
            op_start_o  <= 1'b0;
            op_cmd_o    <= 8'h00;
            op_adr_o    <= 16'h0000;
            op_dat_o    <= 8'h00;
            fetch_adr_o <= 16'h0000;
            secure_o    <= 1'b1;
            bgnd_mode_o <= 1'b0;
            dbg_en_o    <= 1'b0;
            launched_ff <= 1'b0;
        end else begin
            wb_ack_o    <= req;
            wb_dat_o    <= (rd && !(blocked && is_array)) ? {24'h0, rd_byte} : 32'h0;
            mem_wr_o    <= wr & is_array & ~blocked & ~key_access_bit_ff;
            op_start_o  <= go;
            if (go) begin
                op_cmd_o <= cmd_ff;
                op_adr_o <= adr_ff;
                op_dat_o <= dat_ff;
            end
            fetch_adr_o <= redirect ? redir_adr : fetch_adr;
            secure_o    <= secured;
            // strap taken on the first clock after release
            if (!launched_ff) bgnd_mode_o <= ~debug_mode_pin;
            launched_ff <= 1'b1;
            dbg_en_o    <= dbg_enable_req & ~secured;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    error_sticks_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accerr_ff && !clr_err |=> accerr_ff)
        else $error("access error flag dropped without a clear");
    no_div_a: assert property (@(posedge mclk) disable iff (!rst_n)
        arr_wr && !divld_ff |=> accerr_ff)
        else $error("array write before divider not flagged");
    bad_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_code |=> accerr_ff && state_ff == fps_pkg::FPS_IDLE)
        else $error("illegal command not flagged");
    cancel_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_cancel |=> accerr_ff && !op_start_o)
        else $error("cancel did not flag");
    halt_abort_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_halt |=> state_ff == fps_pkg::FPS_IDLE && accerr_ff)
        else $error("halt did not abort");
    sec_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd && blocked && is_array |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("blocked read returned data");
    dbg_sec_a: assert property (@(posedge mclk) disable iff (!rst_n)
        secured |=> !dbg_en_o)
        else $error("debug enabled while secured");
    flag_launch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        accerr_ff |=> !op_start_o)
        else $error("launch while error flag set");
    error_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
        any_err |=> adr_ff == 16'h0000 && cmd_ff == 8'h00)
        else $error("latches kept after error");
    busy_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_cbef |=> accerr_ff && state_ff == fps_pkg::FPS_IDLE)
        else $error("array write while busy not flagged");
    second_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_second |=> accerr_ff && state_ff == fps_pkg::FPS_IDLE)
        else $error("second write not flagged");
    ctl_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_ctlwr |=> accerr_ff)
        else $error("control write in sequence not flagged");
    after_cmd_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_after |=> accerr_ff && !op_start_o)
        else $error("access after command not flagged");
    prot_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        e_prot |=> accerr_ff && !op_start_o)
        else $error("protected target launched");
endmodule : fps_guard

// >>> fps_host.sv
// bus master model of the cpu core and the debug controller
`timescale 1ns/1ps
module fps_host (
    input  wire logic        mclk,          // bus clock
    input  wire logic [31:0] wb_dat_o,      // read data from the guard
    input  wire logic        wb_ack_o,      // acknowledge from the guard
    output logic             wb_cyc_i,      // cycle
    output logic             wb_stb_i,      // strobe
    output logic             wb_we_i,       // write enable
    output logic      [15:0] wb_adr_i,      // byte address
    output logic      [3:0]  wb_sel_i,      // byte lanes
    output logic      [31:0] wb_dat_i,      // write data
    output logic             dbg_access,    // debug controller owns the cycle
    output logic             unsecure_code  // cpu runs from unsecured space
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 16'h0000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0000_0000;
        dbg_access = 1'b0;
        unsecure_code = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one classic cycle, held until ack; the idle gap after it keeps key bytes apart
    task automatic xfer(input logic we, input logic [15:0] adr, input logic [7:0] dat,
                        input logic [1:0] src, output logic [7:0] rd);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, dat};
        dbg_access <= src[0];
        unsecure_code <= src[1];
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) @(posedge mclk);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        dbg_access <= 1'b0;
        unsecure_code <= 1'b0;
        wb_adr_i <= ~adr;  // released lines do not keep the last value
        wb_dat_i <= ~{24'h000000, dat};
    endtask : xfer
endmodule : fps_host

// >>> fps_pkg.sv
// types shared by the flash guard
package fps_pkg;
    typedef enum logic [3:0] {
        FPS_IDLE   = 4'b0001,
        FPS_ADDR   = 4'b0010,
        FPS_CMDQ   = 4'b0100,
        FPS_BUSY   = 4'b1000
    } fps_state_type;
endpackage : fps_pkg

// >>> fps_regs.svh
// register offsets, field positions, command codes and timing counts for the flash guard
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
`define FPS_ADDR_W          16
`define FPS_OFF_DIV         16'h0000
`define FPS_OFF_OPT         16'h0004
`define FPS_OFF_CFG         16'h0008
`define FPS_OFF_PROT        16'h000C
`define FPS_OFF_STAT        16'h0010
`define FPS_OFF_CMD         16'h0014
`define FPS_OFF_KEYCMP      16'h0018
`define FPS_OFF_MISC        16'h001C
`define FPS_OFF_PROTECTION_NV_BYTE      16'hFFBD
`define FPS_OFF_OPTIONS_NV_BYTE       16'hFFBF
`define FPS_BIT_ACCERR      4
`define FPS_BIT_CBEF        7
`define FPS_BIT_CCF         6
`define FPS_BIT_DIVLD       7
`define FPS_BIT_KEY_ACCESS_BIT      5
`define FPS_BIT_BACKDOOR_KEY_ENABLE       7
`define FPS_BIT_NORED       6
`define FPS_BIT_PDIS        0
`define FPS_CMD_BLANK       8'h05
`define FPS_CMD_BYTE        8'h20
`define FPS_CMD_BURST       8'h25
`define FPS_CMD_PAGE        8'h40
`define FPS_CMD_MASS        8'h41
`define FPS_SEC_OPEN        2'h2
`define FPS_VEC_LO          16'hFFC0
`define FPS_VEC_HI          16'hFFFD
`define FPS_OP_TIME_NS      2000
`define FPS_CLK_NS          40
`define FPS_OP_CYCLES       (`FPS_OP_TIME_NS / `FPS_CLK_NS)
`endif
